// ===== motor_starter_supervisor.sv
// supervisory control for a smart soft-starter motor controller
`timescale 1ns/1ps
module motor_starter_supervisor
(
    input  wire logic                                      ref_clk_in,
    input  wire logic                                      rst_in,
    input  wire logic                                      block_enable_in,
    input  wire logic                                      start_cmd_in,
    input  wire logic                                      stop_cmd_in,
    input  wire logic                                      jog_cmd_in,
    input  wire logic                                      reset_cmd_in,
    input  wire logic                                      sim_in,
    input  wire logic                                      run_feedback_in,
    input  wire logic                                      use_run_feedback_in,
    input  wire logic                                      starter_faulted_in,
    input  wire logic                                      comm_failure_in,
    input  wire logic                                      interlock_ok_in,
    input  wire logic                                      nb_interlock_ok_in,
    input  wire logic                                      interlock_bypass_in,
    input  wire logic                                      start_fail_shed_in,
    input  wire logic                                      comm_fault_shed_in,
    input  wire logic [motor_supervisor_pkg::TIME_W-1:0]   start_timeout_ticks_in,
    input  wire logic [motor_supervisor_pkg::TIME_W-1:0]   stop_timeout_ticks_in,
    input  wire logic [motor_supervisor_pkg::SEC_W-1:0]    sim_feedback_seconds,
    output logic                                           motor_run_out,
    output logic                                           motor_jog_out,
    output logic                                           clear_fault_out,
    output logic [3:0]                                     motor_state_out,
    output logic                                           program_oos_out,
    output logic                                           start_timeout_alarm,
    output logic                                           stop_timeout_alarm,
    output logic                                           interlock_trip_alarm,
    output logic                                           comm_fault_alarm,
    output logic                                           starter_fault_alarm,
    output logic                                           start_blocked_out
);
    // command and status pins pass two flip-flops before use; configuration inputs are used directly
    typedef struct packed
    {
        logic [15:0] meta;
        logic [15:0] sync;
    } sync_s;

    typedef struct packed
    {
        logic                                    first_scan_done;
        logic                                    run_cmd;
        logic                                    jog_cmd;
        logic                                    shed_latch;
        logic [motor_supervisor_pkg::TIME_W-1:0] sup_count;
        logic [motor_supervisor_pkg::SIM_W-1:0]  sim_count;
        logic                                    run_out;
        logic                                    jog_out;
        logic                                    clear_fault;
        logic [3:0]                              state;
        logic                                    oos;
        logic                                    a_start;
        logic                                    a_stop;
        logic                                    a_intlk;
        logic                                    a_comm;
        logic                                    a_starter;
    } sup_s;

    sync_s sync_reg;
    sync_s sync_next;
    sup_s  state_reg;
    sup_s  state_next;
    logic  tick;

    scan_tick_gen u_tick
    (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .tick_out   (tick)
    );

    logic [15:0] raw_pins;
    assign raw_pins = {5'h00, block_enable_in, start_cmd_in, stop_cmd_in, jog_cmd_in, reset_cmd_in,
                       sim_in, run_feedback_in, starter_faulted_in, comm_failure_in,
                       interlock_ok_in, nb_interlock_ok_in};

    always_comb
    begin
        sync_next      = sync_reg;
        sync_next.meta = raw_pins;
        sync_next.sync = sync_reg.meta;
    end

    logic en_s;
    logic start_s;
    logic stop_s;
    logic jog_s;
    logic reset_s;
    logic sim_s;
    logic fb_s;
    logic fault_s;
    logic comm_s;
    logic ilk_s;
    logic nbilk_s;
    assign en_s    = sync_reg.sync[10];
    assign start_s = sync_reg.sync[9];
    assign stop_s  = sync_reg.sync[8];
    assign jog_s   = sync_reg.sync[7];
    assign reset_s = sync_reg.sync[6];
    assign sim_s   = sync_reg.sync[5];
    assign fb_s    = sync_reg.sync[4];
    assign fault_s = sync_reg.sync[3];
    assign comm_s  = sync_reg.sync[2];
    assign ilk_s   = sync_reg.sync[1];
    assign nbilk_s = sync_reg.sync[0];

    logic                                    trip;
    logic                                    running_cmd;
    logic                                    fb_used;
    logic [motor_supervisor_pkg::SIM_W-1:0]  sim_limit;

    assign running_cmd = state_reg.run_cmd | state_reg.jog_cmd;
    assign fb_used     = use_run_feedback_in & ~sim_s;
    assign sim_limit   = motor_supervisor_pkg::SIM_W'(sim_feedback_seconds
                         * motor_supervisor_pkg::TICKS_PER_SEC);

    always_comb
    begin
        state_next             = state_reg;
        state_next.clear_fault = 1'b0;
        trip = ~nbilk_s | (~ilk_s & ~interlock_bypass_in);
        if (tick)
        begin
            if (!state_reg.first_scan_done)
            begin
                state_next.first_scan_done = 1'b1;
            end
            else if (!en_s)
            begin
                state_next.run_cmd    = 1'b0;
                state_next.jog_cmd    = 1'b0;
                state_next.shed_latch = 1'b0;
                state_next.oos        = 1'b1;
                state_next.a_start    = 1'b0;
                state_next.a_stop     = 1'b0;
                state_next.a_intlk    = 1'b0;
                state_next.a_comm     = 1'b0;
                state_next.a_starter  = 1'b0;
                state_next.sup_count  = motor_supervisor_pkg::TIME_ZERO;
                state_next.sim_count  = '0;
                state_next.state      = motor_supervisor_pkg::MOTOR_STOPPED;
            end
            else
            begin
                state_next.oos = 1'b0;
                if (reset_s)
                begin
                    state_next.clear_fault = 1'b1;
                    state_next.shed_latch  = 1'b0;
                    state_next.a_start     = 1'b0;
                    state_next.a_stop      = 1'b0;
                    state_next.a_intlk     = 1'b0;
                    state_next.a_comm      = 1'b0;
                    state_next.a_starter   = 1'b0;
                end
                if (stop_s)
                begin
                    state_next.run_cmd = 1'b0;
                end
                else if (start_s && !state_reg.shed_latch && !trip)
                begin
                    state_next.run_cmd = 1'b1;
                end
                state_next.jog_cmd = jog_s & ~stop_s & ~state_reg.shed_latch & ~trip & ~state_next.run_cmd;
                if (running_cmd && trip)
                begin
                    state_next.run_cmd = 1'b0;
                    state_next.jog_cmd = 1'b0;
                    state_next.a_intlk = 1'b1;
                end
                if (comm_s)
                begin
                    state_next.a_comm = 1'b1;
                    if (comm_fault_shed_in)
                    begin
                        state_next.shed_latch = 1'b1;
                        state_next.run_cmd    = 1'b0;
                        state_next.jog_cmd    = 1'b0;
                    end
                end
                if (fault_s)
                begin
                    state_next.a_starter = 1'b1;
                end
                if ((state_next.run_cmd | state_next.jog_cmd) != running_cmd)
                begin
                    state_next.sup_count = motor_supervisor_pkg::TIME_ZERO;
                    state_next.sim_count = '0;
                end
                else
                begin
                    if (state_reg.sup_count != {motor_supervisor_pkg::TIME_W{1'b1}})
                    begin
                        state_next.sup_count = state_reg.sup_count + motor_supervisor_pkg::TIME_ONE;
                    end
                    if (state_reg.sim_count < sim_limit)
                    begin
                        state_next.sim_count = state_reg.sim_count + motor_supervisor_pkg::SIM_ONE;
                    end
                    if (fb_used && running_cmd && !fb_s && state_reg.sup_count >= start_timeout_ticks_in)
                    begin
                        state_next.a_start = 1'b1;
                        if (start_fail_shed_in)
                        begin
                            state_next.shed_latch = 1'b1;
                            state_next.run_cmd    = 1'b0;
                            state_next.jog_cmd    = 1'b0;
                        end
                    end
                    if (fb_used && !running_cmd && fb_s && state_reg.sup_count >= stop_timeout_ticks_in)
                    begin
                        state_next.a_stop = 1'b1;
                    end
                end
                if (sim_s)
                begin
                    if (state_next.run_cmd | state_next.jog_cmd)
                    begin
                        state_next.state = (state_next.sim_count >= sim_limit)
                            ? motor_supervisor_pkg::MOTOR_RUNNING : motor_supervisor_pkg::MOTOR_STARTING;
                    end
                    else
                    begin
                        state_next.state = (state_next.sim_count >= sim_limit)
                            ? motor_supervisor_pkg::MOTOR_STOPPED : motor_supervisor_pkg::MOTOR_STOPPING;
                    end
                end
                else if (state_next.run_cmd | state_next.jog_cmd)
                begin
                    state_next.state = (fb_s || !use_run_feedback_in)
                        ? motor_supervisor_pkg::MOTOR_RUNNING : motor_supervisor_pkg::MOTOR_STARTING;
                end
                else
                begin
                    state_next.state = (fb_s && use_run_feedback_in)
                        ? motor_supervisor_pkg::MOTOR_STOPPING : motor_supervisor_pkg::MOTOR_STOPPED;
                end
            end
        end
        state_next.run_out = state_next.run_cmd & ~sim_s & en_s;
        state_next.jog_out = state_next.jog_cmd & ~sim_s & en_s;
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            sync_reg  <= '0;
            state_reg <= '{state: motor_supervisor_pkg::MOTOR_STOPPED, default: '0};
        end
        else
        begin
            sync_reg  <= sync_next;
            state_reg <= state_next;
        end
    end

    assign motor_run_out        = state_reg.run_out;
    assign motor_jog_out        = state_reg.jog_out;
    assign clear_fault_out      = state_reg.clear_fault;
    assign motor_state_out      = state_reg.state;
    assign program_oos_out      = state_reg.oos;
    assign start_timeout_alarm  = state_reg.a_start;
    assign stop_timeout_alarm   = state_reg.a_stop;
    assign interlock_trip_alarm = state_reg.a_intlk;
    assign comm_fault_alarm     = state_reg.a_comm;
    assign starter_fault_alarm  = state_reg.a_starter;
    assign start_blocked_out    = state_reg.shed_latch;
endmodule : motor_starter_supervisor

// ===== motor_supervisor_pkg.sv
// shared constants for the motor starter supervisor
package motor_supervisor_pkg;
    localparam int unsigned CLK_HZ          = 250_000_000;
    // short scan period keeps supervision times fine-grained
    localparam int unsigned TICK_NS         = 2_000;
    localparam int unsigned TICK_CYCLES     = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned TICK_W          = 18;
    localparam int unsigned TIME_W          = 16;
    localparam int unsigned TICKS_PER_SEC   = 1_000_000_000 / TICK_NS;
    localparam int unsigned SEC_W           = 8;
    localparam int unsigned SIM_W           = 27;
    localparam logic [TIME_W-1:0] TIME_ONE  = 16'h0001;
    localparam logic [SIM_W-1:0]  SIM_ONE   = 27'h0000001;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;

    typedef enum logic [3:0]
    {
        MOTOR_STOPPED  = 4'h1,
        MOTOR_STARTING = 4'h2,
        MOTOR_RUNNING  = 4'h4,
        MOTOR_STOPPING = 4'h8
    } motor_state_e;
endpackage : motor_supervisor_pkg

// ===== scan_tick_gen.sv
// scan clock enable divider
`timescale 1ns/1ps
module scan_tick_gen
(
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    output logic      tick_out
);
    typedef struct packed
    {
        logic [motor_supervisor_pkg::TICK_W-1:0] count;
        logic                                    tick;
    } tick_s;

    tick_s state_reg;
    tick_s state_next;

    always_comb
    begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.count == motor_supervisor_pkg::TICK_W'(motor_supervisor_pkg::TICK_CYCLES - 1))
        begin
            state_next.count = '0;
            state_next.tick  = 1'b1;
        end
        else
        begin
            state_next.count = state_reg.count + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (rst_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign tick_out = state_reg.tick;
endmodule : scan_tick_gen

// ===== motor_starter_supervisor_sva.sv
// assertion checker for the motor starter supervisor
`timescale 1ns/1ps
module starter_sva
(
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    input wire logic       block_enable_in,
    input wire logic       comm_failure_in,
    input wire logic       starter_faulted_in,
    input wire logic       start_fail_shed_in,
    input wire logic       comm_fault_shed_in,
    input wire logic       motor_run_out,
    input wire logic       motor_jog_out,
    input wire logic       clear_fault_out,
    input wire logic [3:0] motor_state_out,
    input wire logic       program_oos_out,
    input wire logic       start_timeout_alarm,
    input wire logic       stop_timeout_alarm,
    input wire logic       interlock_trip_alarm,
    input wire logic       comm_fault_alarm,
    input wire logic       starter_fault_alarm,
    input wire logic       start_blocked_out
);
    localparam int LIMIT = 3 * motor_supervisor_pkg::TICK_CYCLES;
    logic [23:0] comm_cnt_reg;
    logic [23:0] flt_cnt_reg;
    // cycles each fault input has stood while enabled
    always_ff @(posedge ref_clk_in)
    begin
        comm_cnt_reg <= (rst_in || !block_enable_in || !comm_failure_in) ? 24'h000000 : comm_cnt_reg + 24'h000001;
        flt_cnt_reg  <= (rst_in || !block_enable_in || !starter_faulted_in) ? 24'h000000 : flt_cnt_reg + 24'h000001;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_shed_stop;
        ##[0:2] (start_blocked_out && !motor_run_out);
    endsequence
    a_oos_outputs_off: assert property (program_oos_out |-> !motor_run_out && !motor_jog_out)
        else $error("motor output on while out of service");
    a_oos_alarms_clear: assert property (program_oos_out && $past(program_oos_out) |-> !(start_timeout_alarm
        || stop_timeout_alarm || interlock_trip_alarm || comm_fault_alarm || starter_fault_alarm))
        else $error("alarm set while out of service");
    a_state_one_hot: assert property ($onehot(motor_state_out))
        else $error("motor state not one-hot");
    a_clear_one_cycle: assert property (clear_fault_out |=> !clear_fault_out)
        else $error("clear fault pulse longer than one cycle");
    a_blocked_no_start: assert property ($rose(motor_run_out) |-> !start_blocked_out)
        else $error("motor started while blocked");
    a_start_shed_stop: assert property ($rose(start_timeout_alarm) && start_fail_shed_in |-> s_shed_stop)
        else $error("start timeout shed did not stop and block");
    a_comm_shed_stop: assert property ($rose(comm_fault_alarm) && comm_fault_shed_in |-> s_shed_stop)
        else $error("comm fault shed did not stop and block");
    a_comm_alarm_set: assert property (comm_cnt_reg > LIMIT |-> comm_fault_alarm)
        else $error("comm failure without alarm");
    a_fault_alarm_set: assert property (flt_cnt_reg > LIMIT |-> starter_fault_alarm)
        else $error("starter fault without alarm");
    a_trip_stops_run: assert property ($rose(interlock_trip_alarm) |-> ##[0:2] !motor_run_out)
        else $error("interlock trip left motor running");
endmodule : starter_sva

bind motor_starter_supervisor starter_sva chk_i (.ref_clk_in, .rst_in, .block_enable_in, .comm_failure_in,
    .starter_faulted_in, .start_fail_shed_in, .comm_fault_shed_in, .motor_run_out, .motor_jog_out,
    .clear_fault_out, .motor_state_out, .program_oos_out, .start_timeout_alarm, .stop_timeout_alarm,
    .interlock_trip_alarm, .comm_fault_alarm, .starter_fault_alarm, .start_blocked_out);

// ===== starter_model.sv
// behavioural smart starter: run feedback and faulted status
`timescale 1ns/1ps
module starter_model
(
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic       run_cmd_in,
    input  wire logic       clear_fault_in,
    input  wire logic [1:0] fb_mode_in,
    input  wire logic       fault_inject_in,
    output logic            run_feedback_out,
    output logic            faulted_out
);
    // mode 0 follows the run output, 1 stuck off, 2 stuck on
    always_ff @(posedge ref_clk_in)
    begin
        run_feedback_out <= (fb_mode_in == 2'h0) ? run_cmd_in : fb_mode_in[1];
        if (rst_in || clear_fault_in)
            faulted_out <= 1'b0;
        else if (fault_inject_in)
            faulted_out <= 1'b1;
    end
endmodule : starter_model

// ===== tb_motor_starter_supervisor.sv
// self-checking testbench for the motor starter supervisor
`timescale 1ns/1ps
module tb_motor_starter_supervisor;
    logic ref_clk_in, rst_in, block_enable_in, start_cmd_in, stop_cmd_in, jog_cmd_in, reset_cmd_in, sim_in;
    logic run_feedback_in, use_run_feedback_in, starter_faulted_in, comm_failure_in, interlock_ok_in;
    logic nb_interlock_ok_in, interlock_bypass_in, start_fail_shed_in, comm_fault_shed_in, fault_inject;
    logic [motor_supervisor_pkg::TIME_W-1:0] start_timeout_ticks_in, stop_timeout_ticks_in;
    logic [motor_supervisor_pkg::SEC_W-1:0]  sim_feedback_seconds;
    logic motor_run_out, motor_jog_out, clear_fault_out, program_oos_out, start_blocked_out;
    logic start_timeout_alarm, stop_timeout_alarm, interlock_trip_alarm, comm_fault_alarm, starter_fault_alarm;
    logic [3:0] motor_state_out;
    logic [1:0] fb_mode;
    int         failures, samples_checked, clears_seen;

    motor_starter_supervisor dut (.ref_clk_in, .rst_in, .block_enable_in, .start_cmd_in, .stop_cmd_in,
        .jog_cmd_in, .reset_cmd_in, .sim_in, .run_feedback_in, .use_run_feedback_in, .starter_faulted_in,
        .comm_failure_in, .interlock_ok_in, .nb_interlock_ok_in, .interlock_bypass_in, .start_fail_shed_in,
        .comm_fault_shed_in, .start_timeout_ticks_in, .stop_timeout_ticks_in, .sim_feedback_seconds,
        .motor_run_out, .motor_jog_out, .clear_fault_out, .motor_state_out, .program_oos_out,
        .start_timeout_alarm, .stop_timeout_alarm, .interlock_trip_alarm, .comm_fault_alarm,
        .starter_fault_alarm, .start_blocked_out);
    starter_model starter (.ref_clk_in, .rst_in, .run_cmd_in(motor_run_out | motor_jog_out),
        .clear_fault_in(clear_fault_out),
        .fb_mode_in(fb_mode), .fault_inject_in(fault_inject), .run_feedback_out(run_feedback_in),
        .faulted_out(starter_faulted_in));

    always #2 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (clear_fault_out === 1'b1) clears_seen++;

    task automatic tick(input int n);
        repeat (n * motor_supervisor_pkg::TICK_CYCLES) @(posedge ref_clk_in);
    endtask : tick
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // start or stop held over two scans
    task automatic order(input logic go);
        @(posedge ref_clk_in);
        start_cmd_in <= go;
        stop_cmd_in  <= !go;
        tick(2);
        start_cmd_in <= 1'b0;
        stop_cmd_in  <= 1'b0;
    endtask : order
    task automatic clear();
        reset_cmd_in <= 1'b1;
        tick(2);
        reset_cmd_in <= 1'b0;
        tick(1);
    endtask : clear
    task automatic pulse_fault();
        fault_inject <= 1'b1;
        @(posedge ref_clk_in);
        fault_inject <= 1'b0;
    endtask : pulse_fault
    task automatic t_first_scan();
        start_cmd_in <= 1'b1;
        repeat (motor_supervisor_pkg::TICK_CYCLES) @(posedge ref_clk_in);
        start_cmd_in <= 1'b0;
        tick(3);
        chk(motor_run_out, 1'b1 ^ 1'b1);
        chk(motor_state_out, 4'h1);
    endtask : t_first_scan
    task automatic t_start_fail();
        fb_mode <= 2'h1;
        order(1'b1);
        tick(4);
        chk(start_timeout_alarm, 1'b1);
        chk(start_blocked_out, 1'b1);
        order(1'b1);
        chk(motor_run_out, 1'b0);
        fb_mode <= 2'h0;
        clear();
        chk(clears_seen != 0, 1'b1);
        chk(start_blocked_out, 1'b0);
        chk(start_timeout_alarm, 1'b0);
    endtask : t_start_fail
    task automatic t_stop_fail();
        order(1'b1);
        chk(motor_run_out, 1'b1);
        fb_mode <= 2'h2;
        order(1'b0);
        tick(4);
        chk(stop_timeout_alarm, 1'b1);
        chk(motor_run_out, 1'b0);
        fb_mode <= 2'h0;
        clear();
    endtask : t_stop_fail
    task automatic t_interlock();
        interlock_bypass_in <= 1'b1;
        order(1'b1);
        interlock_ok_in <= 1'b0;
        tick(2);
        chk(interlock_trip_alarm, 1'b0);
        chk(motor_run_out, 1'b1);
        nb_interlock_ok_in <= 1'b0;
        tick(2);
        chk(interlock_trip_alarm, 1'b1);
        chk(motor_run_out, 1'b0);
        {interlock_ok_in, nb_interlock_ok_in, interlock_bypass_in} <= 3'h6;
        clear();
        order(1'b1);
        interlock_ok_in <= 1'b0;
        tick(2);
        chk(interlock_trip_alarm, 1'b1);
        chk(motor_run_out, 1'b0);
        interlock_ok_in <= 1'b1;
        clear();
    endtask : t_interlock
    task automatic t_comm();
        order(1'b1);
        comm_failure_in <= 1'b1;
        tick(2);
        chk(comm_fault_alarm, 1'b1);
        order(1'b1);
        chk(motor_run_out, 1'b0);
        comm_failure_in <= 1'b0;
        clear();
        chk(comm_fault_alarm, 1'b0);
        chk(start_blocked_out, 1'b0);
    endtask : t_comm
    task automatic t_fault();
        pulse_fault();
        tick(2);
        chk(starter_fault_alarm, 1'b1);
        clear();
        chk(starter_faulted_in, 1'b0);
        chk(starter_fault_alarm, 1'b0);
    endtask : t_fault
    task automatic t_sim();
        sim_in <= 1'b1;
        tick(2);
        order(1'b1);
        chk(motor_run_out, 1'b0);
        chk(motor_state_out, 4'h4);
        order(1'b0);
        chk(motor_state_out, 4'h1);
        jog_cmd_in <= 1'b1;
        tick(2);
        chk(motor_jog_out, 1'b0);
        chk(motor_state_out, 4'h4);
        jog_cmd_in <= 1'b0;
        sim_feedback_seconds <= 8'h01;
        order(1'b1);
        chk(motor_state_out, 4'h2);
        order(1'b0);
        chk(motor_state_out, 4'h8);
        sim_feedback_seconds <= 8'h00;
        sim_in <= 1'b0;
        tick(3);
        jog_cmd_in <= 1'b1;
        tick(2);
        chk(motor_jog_out, 1'b1);
        jog_cmd_in <= 1'b0;
        tick(2);
    endtask : t_sim
    task automatic t_disable();
        order(1'b1);
        pulse_fault();
        tick(2);
        block_enable_in <= 1'b0;
        tick(3);
        chk(program_oos_out, 1'b1);
        chk(starter_fault_alarm, 1'b0);
        chk(motor_run_out, 1'b0);
        block_enable_in <= 1'b1;
        clear();
        chk(program_oos_out, 1'b0);
    endtask : t_disable
    task automatic close_out();
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial
    begin
        ref_clk_in = 1'b0;
        rst_in = 1'b1;
        fb_mode = 2'h0;
        start_timeout_ticks_in = 16'h0003;
        stop_timeout_ticks_in = 16'h0003;
        sim_feedback_seconds = 8'h00;
        {start_cmd_in, stop_cmd_in, jog_cmd_in, reset_cmd_in, sim_in, comm_failure_in} = 6'h00;
        {interlock_bypass_in, fault_inject} = 2'h0;
        {block_enable_in, use_run_feedback_in, interlock_ok_in, nb_interlock_ok_in} = 4'hf;
        {start_fail_shed_in, comm_fault_shed_in} = 2'h3;
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_first_scan();
        t_start_fail();
        t_stop_fail();
        t_interlock();
        t_comm();
        t_fault();
        t_sim();
        t_disable();
        close_out();
    end
    initial
    begin
        tick(120);
        failures++;
        close_out();
    end
endmodule : tb_motor_starter_supervisor
